// File: logic/clcc_regs.vh
`ifndef CLCC_REGS_VH
`define CLCC_REGS_VH

// register indices; byte address is four times the index
`define CLCC_IDX_CONTROL 14'h0e27
`define CLCC_IDX_POLARITY 14'h0e28
`define CLCC_IDX_SEL_ONE 14'h0e29
`define CLCC_IDX_SEL_TWO 14'h0e2a
`define CLCC_IDX_SEL_THREE 14'h0e2b
`define CLCC_IDX_GATE_ONE 14'h0e2d
`define CLCC_IDX_GATE_TWO 14'h0e2e
`define CLCC_IDX_GATE_THREE 14'h0e2f
`define CLCC_IDX_GATE_FOUR 14'h0e30
`define CLCC_IDX_IRQ_STATUS 14'h0e78
`define CLCC_IDX_IRQ_MASK 14'h0e79

// control register fields
`define CLCC_CTL_ENABLE 7
`define CLCC_CTL_OUTPUT 5
`define CLCC_CTL_RISE_IRQ 4
`define CLCC_CTL_FALL_IRQ 3
`define CLCC_CTL_MODE_HI 2
`define CLCC_CTL_MODE_LO 0
`define CLCC_CTL_RESET 8'h00

// polarity register fields
`define CLCC_POL_OUTPUT 7
`define CLCC_POL_OUTPUT_RESET 1'b0

// irq status / mask
`define CLCC_IRQ_FLAG 0
`define CLCC_IRQ_RESET 1'b0

// functional modes
`define CLCC_MODE_AND_OR 3'h0
`define CLCC_MODE_OR_XOR 3'h1
`define CLCC_MODE_AND4 3'h2
`define CLCC_MODE_SR_LATCH 3'h3
`define CLCC_MODE_DFF_SR 3'h4
`define CLCC_MODE_DFF2_R 3'h5
`define CLCC_MODE_JK_R 3'h6
`define CLCC_MODE_LATCH_SR 3'h7

// axi responses
`define CLCC_RESP_OKAY 2'h0
`define CLCC_RESP_SLVERR 2'h2

`endif

// File: logic/clcc_gate_mux.v
`timescale 1ns/1ps
`include "clcc_regs.vh"

module clcc_gate_mux #(
  parameter NUM_SRC = 64
) (
  input wire [NUM_SRC-1:0] source_in,
  input wire [5:0] input_one_source,
  input wire [5:0] input_two_source,
  input wire [5:0] input_three_source,
  input wire [23:0] gate_sel_flat,
  input wire [3:0] gate_invert,
  output reg [3:0] gates
);

  // out-of-range select reads as zero rather than x
  function pick;
    input [NUM_SRC-1:0] src;
    input [5:0] sel;
    begin
      if (sel < NUM_SRC)
        pick = src[sel];
      else
        pick = 1'b0;
    end
  endfunction

  wire [2:0] data;
  assign data[0] = pick(source_in, input_one_source); // [R14]
  assign data[1] = pick(source_in, input_two_source); // [R15]
  assign data[2] = pick(source_in, input_three_source); // [R16]

  integer g;
  integer y;
  reg acc;
  always @*
  begin
    acc = 1'b0;
    gates = 4'h0;
    for (g = 0; g < 4; g = g + 1)
    begin
      acc = 1'b0;
      for (y = 0; y < 3; y = y + 1)
      begin
        // odd bit gates the true copy, even bit the negated copy
        acc = acc | (gate_sel_flat[g*6+y*2+1] & data[y]) |
          (gate_sel_flat[g*6+y*2] & ~data[y]); // [R17]
      end
      gates[g] = acc ^ gate_invert[g]; // [R12]
    end
  end

endmodule // clcc_gate_mux

// File: logic/clcc_cell_core.v
`timescale 1ns/1ps
`include "clcc_regs.vh"

module clcc_cell_core (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire [2:0] mode,
  input wire [3:0] gates,
  output reg cell_value
);

  // sequential modes are sampled on aclk; gate 1 edges seen one cycle late
  reg q_ff;
  reg nxt_q;
  reg clk_prev_ff;
  wire g1;
  wire g2;
  wire g3;
  wire g4;
  wire g1_rise;
  assign g1 = gates[0];
  assign g2 = gates[1];
  assign g3 = gates[2];
  assign g4 = gates[3];
  assign g1_rise = g1 & ~clk_prev_ff;

  always @*
  begin
    nxt_q = q_ff;
    case (mode)
      `CLCC_MODE_SR_LATCH:
      begin
        if (g1 | g2)
          nxt_q = 1'b1; // [R07]
        else if (g3 | g4)
          nxt_q = 1'b0;
      end
      `CLCC_MODE_DFF_SR:
      begin
        if (g4)
          nxt_q = 1'b1; // [R07]
        else if (g3)
          nxt_q = 1'b0;
        else if (g1_rise)
          nxt_q = g2;
      end
      `CLCC_MODE_DFF2_R:
      begin
        if (g3)
          nxt_q = 1'b0; // [R08]
        else if (g1_rise)
          nxt_q = g2 & g4;
      end
      `CLCC_MODE_JK_R:
      begin
        if (g3)
          nxt_q = 1'b0; // [R09]
        else if (g1_rise)
          nxt_q = (g2 & ~q_ff) | (~g4 & q_ff);
      end
      `CLCC_MODE_LATCH_SR:
      begin
        if (g4)
          nxt_q = 1'b1; // [R10]
        else if (g3)
          nxt_q = 1'b0;
        else if (g1)
          nxt_q = g2;
      end
      default:
        nxt_q = q_ff;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      q_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      q_ff <= nxt_q; // [R01]
      clk_prev_ff <= g1;
    end
  end

  always @*
  begin
    case (mode)
      `CLCC_MODE_AND_OR:
        cell_value = (g1 & g2) | (g3 & g4); // [R06]
      `CLCC_MODE_OR_XOR:
        cell_value = (g1 | g2) ^ (g3 | g4); // [R06]
      `CLCC_MODE_AND4:
        cell_value = g1 & g2 & g3 & g4; // [R06]
      `CLCC_MODE_LATCH_SR:
        cell_value = nxt_q; // transparent path
      default:
        cell_value = q_ff;
    endcase
  end

endmodule // clcc_cell_core

// File: logic/clcc_top.v
`timescale 1ns/1ps
`include "clcc_regs.vh"
// Contract
// [R01] Enabled cell combines its selected inputs per chosen mode.
// [R02] Disabled cell outputs logic zero.
// [R03] Polarity-applied output reads at control bit 5; writes ignored.
// [R04] Rise irq enable at bit 4 sets flag on output rising edge.
// [R05] Fall irq enable at bit 3 sets flag on output falling edge.
// [R06] Mode 000 AND-OR, 001 OR-XOR, 010 four-input AND.
// [R07] Mode 011 S-R latch, 100 D flip-flop with set and reset.
// [R08] Mode 101 two-input D flip-flop with reset.
// [R09] Mode 110 J-K flip-flop with reset.
// [R10] Mode 111 transparent latch with set and reset.
// [R11] Polarity bit 7 inverts the cell output.
// [R12] Gate polarity bits 0..3 invert each gate before the function.
// [R13] Gate polarity bits are not touched by the system reset.
// [R14] First select field bits 5:0 picks data input one.
// [R15] Second select field picks data input two; kept across reset.
// [R16] Third select field bits 5:0 picks data input three.
// [R17] Gate bit pairs include true or negated data copies into gates.
// [R18] Edges found by comparing registered output with previous cycle.
// [R19] Control register resets to zero: disabled, irqs off, AND-OR.

module clcc_top #(
  parameter NUM_SRC = 64,
  parameter ADDR_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_SRC-1:0] source_in,
  output reg cell_output,
  output reg cell_irq
);

  reg [7:0] control_ff;
  reg output_invert_ff;
  reg [3:0] gate_invert_ff;
  reg [5:0] input_one_source_ff;
  reg [5:0] input_two_source_ff;
  reg [5:0] input_three_source_ff;
  reg [5:0] gate_sel_ff [0:3];
  reg cell_irq_flag_ff;
  reg irq_mask_ff;
  reg out_prev_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg aw_held_ff;
  reg [7:0] w_byte_ff;
  reg w_lane_ff;
  reg w_held_ff;

  function [13:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      reg_index = addr[15:2];
    end
  endfunction

  function is_mapped;
    input [13:0] idx;
    begin
      case (idx)
        `CLCC_IDX_CONTROL, `CLCC_IDX_POLARITY, `CLCC_IDX_SEL_ONE,
        `CLCC_IDX_SEL_TWO, `CLCC_IDX_SEL_THREE, `CLCC_IDX_GATE_ONE,
        `CLCC_IDX_GATE_TWO, `CLCC_IDX_GATE_THREE, `CLCC_IDX_GATE_FOUR,
        `CLCC_IDX_IRQ_STATUS, `CLCC_IDX_IRQ_MASK:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // write commits once both address and data are held
  wire wr_fire;
  wire [13:0] wr_idx;
  wire wr_en;
  assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr_ff);
  assign wr_en = wr_fire & w_lane_ff;

  wire rd_fire;
  wire [13:0] rd_idx;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx = reg_index(s_axi_araddr);

  // one decoded strobe per writable register keeps the update blocks flat
  wire hit_control;
  wire hit_polarity;
  wire hit_sel_one;
  wire hit_sel_two;
  wire hit_sel_three;
  wire hit_gate_one;
  wire hit_gate_two;
  wire hit_gate_three;
  wire hit_gate_four;
  wire hit_irq_mask;
  assign hit_control = (wr_idx == `CLCC_IDX_CONTROL);
  assign hit_polarity = (wr_idx == `CLCC_IDX_POLARITY);
  assign hit_sel_one = (wr_idx == `CLCC_IDX_SEL_ONE);
  assign hit_sel_two = (wr_idx == `CLCC_IDX_SEL_TWO);
  assign hit_sel_three = (wr_idx == `CLCC_IDX_SEL_THREE);
  assign hit_gate_one = (wr_idx == `CLCC_IDX_GATE_ONE);
  assign hit_gate_two = (wr_idx == `CLCC_IDX_GATE_TWO);
  assign hit_gate_three = (wr_idx == `CLCC_IDX_GATE_THREE);
  assign hit_gate_four = (wr_idx == `CLCC_IDX_GATE_FOUR);
  assign hit_irq_mask = (wr_idx == `CLCC_IDX_IRQ_MASK);

  // bit 6 is unimplemented and must read zero, so it is never stored
  localparam [7:0] CTL_WR_MASK = 8'h9f;

  // write channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CLCC_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_byte_ff <= 8'h00;
      w_lane_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
        w_held_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_idx) ? `CLCC_RESP_OKAY : `CLCC_RESP_SLVERR;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // registers with a defined reset value
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_ff <= `CLCC_CTL_RESET; // [R19]
      output_invert_ff <= `CLCC_POL_OUTPUT_RESET;
      irq_mask_ff <= `CLCC_IRQ_RESET;
    end
    else if (wr_en)
    begin
      if (hit_control)
      begin
        // output bit is not stored; it always reads the live cell output
        control_ff <= w_byte_ff & CTL_WR_MASK; // [R03]
      end
      if (hit_polarity)
        output_invert_ff <= w_byte_ff[`CLCC_POL_OUTPUT];
      if (hit_irq_mask)
        irq_mask_ff <= w_byte_ff[`CLCC_IRQ_FLAG];
    end
  end

  // configuration kept across the system reset; power-up value is unknown
  always @(posedge aclk)
  begin
    if (wr_en)
    begin
      if (hit_polarity)
        gate_invert_ff <= w_byte_ff[3:0]; // [R13]
      if (hit_sel_one)
        input_one_source_ff <= w_byte_ff[5:0]; // [R14]
      if (hit_sel_two)
        input_two_source_ff <= w_byte_ff[5:0]; // [R15]
      if (hit_sel_three)
        input_three_source_ff <= w_byte_ff[5:0]; // [R16]
      if (hit_gate_one)
        gate_sel_ff[0] <= w_byte_ff[5:0];
      if (hit_gate_two)
        gate_sel_ff[1] <= w_byte_ff[5:0];
      if (hit_gate_three)
        gate_sel_ff[2] <= w_byte_ff[5:0];
      if (hit_gate_four)
        gate_sel_ff[3] <= w_byte_ff[5:0];
    end
  end

  wire [3:0] gates;
  clcc_gate_mux #(
    .NUM_SRC(NUM_SRC)
  ) u_gate_mux (
    .source_in(source_in),
    .input_one_source(input_one_source_ff),
    .input_two_source(input_two_source_ff),
    .input_three_source(input_three_source_ff),
    .gate_sel_flat({gate_sel_ff[3], gate_sel_ff[2], gate_sel_ff[1], gate_sel_ff[0]}),
    .gate_invert(gate_invert_ff),
    .gates(gates)
  );

  wire cell_enable;
  wire cell_value;
  assign cell_enable = control_ff[`CLCC_CTL_ENABLE];
  clcc_cell_core u_cell_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(cell_enable),
    .mode(control_ff[`CLCC_CTL_MODE_HI:`CLCC_CTL_MODE_LO]),
    .gates(gates),
    .cell_value(cell_value)
  );

  // polarity is applied before the enable gate so a disabled cell reads zero
  wire nxt_cell_output;
  assign nxt_cell_output = cell_enable & (cell_value ^ output_invert_ff); // [R02] [R11]

  wire rise_edge;
  wire fall_edge;
  wire irq_set;
  wire irq_clr;
  wire nxt_irq_flag;
  assign rise_edge = cell_output & ~out_prev_ff; // [R18]
  assign fall_edge = ~cell_output & out_prev_ff; // [R18]
  assign irq_set = (rise_edge & control_ff[`CLCC_CTL_RISE_IRQ]) | // [R04]
    (fall_edge & control_ff[`CLCC_CTL_FALL_IRQ]); // [R05]
  assign irq_clr = rd_fire & (rd_idx == `CLCC_IDX_IRQ_STATUS);
  // a new edge in the clearing cycle survives the read
  assign nxt_irq_flag = irq_set | (cell_irq_flag_ff & ~irq_clr);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cell_output <= 1'b0;
      out_prev_ff <= 1'b0;
      cell_irq_flag_ff <= `CLCC_IRQ_RESET;
      cell_irq <= 1'b0;
    end
    else
    begin
      cell_output <= nxt_cell_output; // [R01]
      out_prev_ff <= cell_output;
      cell_irq_flag_ff <= nxt_irq_flag;
      cell_irq <= cell_irq_flag_ff & irq_mask_ff;
    end
  end

  reg [7:0] rd_byte;
  always @*
  begin
    rd_byte = 8'h00;
    case (rd_idx)
      `CLCC_IDX_CONTROL:
      begin
        rd_byte = control_ff;
        rd_byte[`CLCC_CTL_OUTPUT] = cell_output; // [R03]
      end
      `CLCC_IDX_POLARITY:
        rd_byte = {output_invert_ff, 3'h0, gate_invert_ff};
      `CLCC_IDX_SEL_ONE:
        rd_byte = {2'h0, input_one_source_ff};
      `CLCC_IDX_SEL_TWO:
        rd_byte = {2'h0, input_two_source_ff};
      `CLCC_IDX_SEL_THREE:
        rd_byte = {2'h0, input_three_source_ff};
      `CLCC_IDX_GATE_ONE:
        rd_byte = {2'h0, gate_sel_ff[0]};
      `CLCC_IDX_GATE_TWO:
        rd_byte = {2'h0, gate_sel_ff[1]};
      `CLCC_IDX_GATE_THREE:
        rd_byte = {2'h0, gate_sel_ff[2]};
      `CLCC_IDX_GATE_FOUR:
        rd_byte = {2'h0, gate_sel_ff[3]};
      `CLCC_IDX_IRQ_STATUS:
        rd_byte = {7'h00, cell_irq_flag_ff};
      `CLCC_IDX_IRQ_MASK:
        rd_byte = {7'h00, irq_mask_ff};
      default:
        rd_byte = 8'h00;
    endcase
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CLCC_RESP_OKAY;
    end
    else
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= is_mapped(rd_idx) ? `CLCC_RESP_OKAY : `CLCC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // clcc_top

// File: test/clcc_chk.sv
`timescale 1ns/1ps
`include "clcc_regs.vh"
module clcc_chk #(
  parameter ADDR_W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cell_output,
  input wire cell_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_take;
    s_axi_bvalid && s_axi_bready;
  endsequence
  property p_rd_ans;
    s_ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  // read data is captured at the take edge, so it shows the output one cycle back
  property p_ctl_rd;
    s_ar_take ##0 (s_axi_araddr[ADDR_W-1:2] == `CLCC_IDX_CONTROL)
      |=> s_axi_rdata[6:5] == {1'b0, $past(cell_output)};
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("output bit wrong");
  property p_unm;
    s_ar_take ##0 (s_axi_araddr[ADDR_W-1:2] == 14'h0e2c)
      |=> s_axi_rresp == `CLCC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answered");
  property p_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_wr_ans;
    s_wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_b_done;
    s_b_take |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write not closed");
  property p_rst;
    $rose(aresetn) |-> !cell_output && !cell_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("output after reset");
endmodule // clcc_chk
bind clcc_top clcc_chk #(.ADDR_W(ADDR_W)) u_clcc_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cell_output(cell_output), .cell_irq(cell_irq));

// File: test/clcc_src_model.sv
`timescale 1ns/1ps
module clcc_src_model (
  input wire aclk,
  input wire [63:0] drive,
  output logic [63:0] source_in
);
  // on-chip sources change only just after the edge
  always @(posedge aclk)
    source_in <= drive;
endmodule // clcc_src_model

// File: test/clcc_top_test.sv
`timescale 1ns/1ps
`include "clcc_regs.vh"
module clcc_top_test;
  logic aclk, aresetn, aw, w, ar, awr, wrd, bv, arr, rv, out, irq, f;
  logic [1:0] bre, rre;
  logic [2:0] m, e;
  logic [3:0] g;
  logic [7:0] p;
  logic [15:0] awa, ara, lf_ff;
  logic [31:0] wd, rdat;
  logic [63:0] drv, src;
  logic [33:0] bq[$], rq[$];
  int err_total, check_count, n;
  clcc_top u_clcc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(w), .s_axi_wready(wrd), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .source_in(src), .cell_output(out),
    .cell_irq(irq));
  clcc_src_model u_clcc_src_model (.aclk(aclk), .drive(drv), .source_in(src));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic [15:0] nxt_lf(input [15:0] s);
    nxt_lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: bus answer %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: cell bit %b expected %b", $time, got, exp);
    end
  endtask
  // bready and rready stay high, so the answer edge is the handshake edge
  task automatic wreg(input [13:0] i, input [7:0] d, input [1:0] r = `CLCC_RESP_OKAY);
    bq.push_back({r, 32'h0000_0000});
    awa <= {i, 2'b00};
    wd <= {24'h00_0000, d};
    aw <= 1'b1;
    w <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awr)
        aw <= 1'b0;
      if (wrd)
        w <= 1'b0;
      n++;
    end
    while (!bv && n < 50);
    if (!bv)
    begin
      err_total++;
      $display("Error at %0t: write not answered", $time);
    end
  endtask
  task automatic rreg(input [13:0] i, input [7:0] d, input [1:0] r = `CLCC_RESP_OKAY);
    rq.push_back({r, 24'h00_0000, d});
    ara <= {i, 2'b00};
    ar <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arr)
        ar <= 1'b0;
      n++;
    end
    while (!rv && n < 50);
    if (!rv)
    begin
      err_total++;
      $display("Error at %0t: read not answered", $time);
    end
  endtask
  always @(posedge aclk)
  begin
    if (bv)
      cmp_bus({bre, 32'h0000_0000}, bq.pop_front());
    if (rv)
      cmp_bus({rre, rdat}, rq.pop_front());
  end
  // five cycles cover source stage, flop state, flag and irq stages
  task automatic go(input [2:0] d);
    lf_ff = nxt_lf(lf_ff);
    drv <= {lf_ff, lf_ff, lf_ff, lf_ff[12:0], d};
    repeat (5) @(posedge aclk);
  endtask
  task automatic sq(input [2:0] md, input [7:0] pl, input [15:0] st);
    wreg(`CLCC_IDX_CONTROL, 8'h00);
    wreg(`CLCC_IDX_POLARITY, pl | 8'h80);
    go(3'h7);
    cmp_bit(out, 1'b0);
    wreg(`CLCC_IDX_POLARITY, pl);
    go(3'h0);
    wreg(`CLCC_IDX_CONTROL, {5'h10, md});
    for (int k = 3; k >= 0; k--)
    begin
      go(st[4*k+1 +: 3]);
      cmp_bit(out, st[4*k]);
    end
    $display("mode %0d done", md);
  endtask
  task automatic ev(input [2:0] d, input fl, input iq);
    go(d);
    cmp_bit(irq, iq);
    rreg(`CLCC_IDX_IRQ_STATUS, {7'h00, fl});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    results;
  end
  initial
  begin
    {aresetn, aw, w, ar, awa, ara, wd, drv} = '0;
    lf_ff = 16'had76;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(`CLCC_IDX_CONTROL, 8'h00);
    rreg(`CLCC_IDX_IRQ_STATUS, 8'h00);
    rreg(`CLCC_IDX_IRQ_MASK, 8'h00);
    rreg(14'h0e2c, 8'h00, `CLCC_RESP_SLVERR);
    wreg(14'h0e2c, 8'hff, `CLCC_RESP_SLVERR);
    wreg(`CLCC_IDX_CONTROL, 8'h67);
    rreg(`CLCC_IDX_CONTROL, 8'h07);
    $display("register test done");
    for (int i = 0; i < 3; i++)
    begin
      lf_ff = nxt_lf(lf_ff);
      wreg(14'(`CLCC_IDX_SEL_ONE + i), lf_ff[7:0]);
      rreg(14'(`CLCC_IDX_SEL_ONE + i), lf_ff[7:0] & 8'h3f);
      wreg(14'(`CLCC_IDX_SEL_ONE + i), 8'(i));
      wreg(14'(`CLCC_IDX_GATE_ONE + i), 8'(8'h02 << (2 * i)));
    end
    wreg(`CLCC_IDX_GATE_FOUR, 8'h00);
    wreg(`CLCC_IDX_POLARITY, 8'h85);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rreg(`CLCC_IDX_POLARITY, 8'h05);
    rreg(`CLCC_IDX_SEL_TWO, 8'h01);
    rreg(`CLCC_IDX_CONTROL, 8'h00);
    $display("select and reset test done");
    for (int i = 0; i < 12; i++)
    begin
      lf_ff = nxt_lf(lf_ff);
      p = lf_ff[7:0] & 8'h8f;
      e = lf_ff[12:10];
      m = 3'(i % 3);
      wreg(`CLCC_IDX_POLARITY, p);
      wreg(`CLCC_IDX_CONTROL, {5'h10, m});
      go(e);
      g = {p[3], e ^ p[2:0]};
      f = m == 0 ? (g[0] & g[1]) | (g[2] & g[3]) : m == 1 ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g;
      f = f ^ p[7];
      cmp_bit(out, f);
      rreg(`CLCC_IDX_CONTROL, {2'b10, f, 2'b00, m});
    end
    $display("gate mode test done");
    sq(`CLCC_MODE_SR_LATCH, 8'h00, 16'h5183);
    sq(`CLCC_MODE_DFF_SR, 8'h00, 16'h4718);
    sq(`CLCC_MODE_DFF2_R, 8'h08, 16'h4718);
    sq(`CLCC_MODE_JK_R, 8'h08, 16'h4756);
    sq(`CLCC_MODE_LATCH_SR, 8'h00, 16'h7247);
    wreg(`CLCC_IDX_CONTROL, 8'h00);
    wreg(`CLCC_IDX_POLARITY, 8'h00);
    wreg(`CLCC_IDX_IRQ_MASK, 8'h01);
    go(3'h0);
    wreg(`CLCC_IDX_CONTROL, 8'h90);
    ev(3'h3, 1'b1, 1'b1);
    ev(3'h0, 1'b0, 1'b0);
    wreg(`CLCC_IDX_CONTROL, 8'h88);
    ev(3'h3, 1'b0, 1'b0);
    wreg(`CLCC_IDX_IRQ_MASK, 8'h00);
    ev(3'h0, 1'b1, 1'b0);
    $display("edge irq test done");
    results;
  end
endmodule // clcc_top_test
